// >>> core/sled_top.sv
// status lamp sequencer and user switch front end of the pressure transducer
`timescale 1ns/1ps
`default_nettype none
module sled_top #(
  parameter logic [31:0] POWERUP_CYC = sled_pkg::POWERUP_CYC,
  parameter logic [31:0] SLOW_HALF_CYC = sled_pkg::SLOW_HALF_CYC,
  parameter logic [31:0] FAST_HALF_CYC = sled_pkg::FAST_HALF_CYC,
  parameter logic [31:0] BURST_HALF_CYC = sled_pkg::BURST_HALF_CYC,
  parameter logic [31:0] DEBOUNCE_CYC = sled_pkg::DEBOUNCE_CYC,
  parameter logic [31:0] ATM_HOLD_CYC = sled_pkg::ATM_HOLD_CYC,
  parameter logic [31:0] UPGRADE_HOLD_CYC = sled_pkg::UPGRADE_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic testModeActive,
  input wire logic hvOn,
  input wire logic ionStarted,
  input wire logic sensorFail,
  input wire logic upgradeActive,
  input wire logic adjustDone,
  input wire logic adjustOk,
  input wire logic switchPressed,
  input wire logic customerParams,
  input wire logic switchReEnabled,
  input wire logic factoryStore,
  input wire logic [sled_pkg::ADJ_W-1:0] factoryZeroIn,
  input wire logic [sled_pkg::ADJ_W-1:0] factoryAtmIn,
  input wire logic restoreFactoryZeroCommand,
  input wire logic restoreFactoryAtmosphereCommand,
  output logic ledRed,
  output logic ledGreen,
  output logic powerUpDone,
  output logic vacuumZeroCommand,
  output logic atmosphereAdjustCommand,
  output logic upgradeEntryCommand,
  output logic [sled_pkg::ADJ_W-1:0] restoredZero,
  output logic [sled_pkg::ADJ_W-1:0] restoredAtm,
  output logic restoredZeroValid,
  output logic restoredAtmValid
);
  import sled_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] halfPeriod(input logic [2:0] pat);
    case (pat)
      PAT_GREEN_SLOW: halfPeriod = SLOW_HALF_CYC;
      PAT_GREEN_FAST: halfPeriod = FAST_HALF_CYC;
      PAT_RED_FAST: halfPeriod = FAST_HALF_CYC;
      default: halfPeriod = 32'h0;
    endcase
  endfunction : halfPeriod

  function automatic logic isBlinking(input logic [2:0] pat);
    isBlinking = (pat == PAT_GREEN_SLOW) || (pat == PAT_GREEN_FAST) || (pat == PAT_RED_FAST);
  endfunction : isBlinking

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state

  sled_state_t state;
  sled_state_t next_state;
  logic [31:0] seqCnt;
  logic [2:0] burstStep;
  logic burstGreen;
  logic [31:0] blinkCnt;
  logic blinkOn;
  logic [2:0] lastPattern;

  wire puEnd = (state == ST_POWERUP) && (seqCnt >= POWERUP_CYC - 32'h1);
  wire burstHalfEnd = (state == ST_BURST) && (seqCnt >= BURST_HALF_CYC - 32'h1);
  wire burstLast = burstStep == 3'((BURST_FLASHES << 1) - 3'h1);
  // a result arriving during a burst restarts it with the newer outcome
  wire burstStart = adjustDone && (state != ST_POWERUP);

  always_comb begin
    next_state = state;
    case (state)
      ST_POWERUP: begin
        if (puEnd) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (burstStart) next_state = ST_BURST;
      end
      ST_BURST: begin
        if (burstStart) next_state = ST_BURST;
        else if (burstHalfEnd && burstLast) next_state = ST_RUN;
      end
      default: next_state = ST_POWERUP;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_POWERUP;
      seqCnt <= 32'h0;
      burstStep <= 3'h0;
      burstGreen <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      if (burstStart) begin
        seqCnt <= 32'h0;
        burstStep <= 3'h0;
        burstGreen <= adjustOk;
      end else if (burstHalfEnd || puEnd) begin
        seqCnt <= 32'h0;
        burstStep <= burstStep + 3'h1;
      end else if (state != ST_RUN) begin
        seqCnt <= seqCnt + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pattern selection, highest priority first

  wire [2:0] runPattern =
    testModeActive ? PAT_GREEN_SLOW :
    (hvOn && ionStarted) ? PAT_GREEN_FAST :
    (hvOn && !ionStarted) ? PAT_RED_FAST :
    PAT_GREEN;
  wire [2:0] burstPattern = burstStep[0] ? PAT_OFF : (burstGreen ? PAT_GREEN : PAT_RED);
  wire [2:0] selPattern =
    (state == ST_POWERUP) ? PAT_RED :
    upgradeActive ? PAT_OFF :
    sensorFail ? PAT_RED :
    (state == ST_BURST) ? burstPattern :
    runPattern;

  // the blink timer restarts lit whenever the pattern changes, so a new
  // state is always seen at once instead of waiting out a dark half
  wire patChange = selPattern != lastPattern;
  wire blinkEdge = isBlinking(selPattern) && (blinkCnt >= halfPeriod(selPattern) - 32'h1);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lastPattern <= PAT_RED;
      blinkCnt <= 32'h0;
      blinkOn <= 1'b1;
    end else if (ce) begin
      lastPattern <= selPattern;
      if (patChange || !isBlinking(selPattern)) begin
        // the change cycle is already lit, so it counts as the first lit cycle
        blinkCnt <= patChange ? 32'h1 : 32'h0;
        blinkOn <= 1'b1;
      end else if (blinkEdge) begin
        blinkCnt <= 32'h0;
        blinkOn <= !blinkOn;
      end else begin
        blinkCnt <= blinkCnt + 32'h1;
      end
    end
  end

  wire litNow = patChange || blinkOn;
  wire next_red = ((selPattern == PAT_RED) || ((selPattern == PAT_RED_FAST) && litNow));
  wire next_green = (selPattern == PAT_GREEN) ||
    (((selPattern == PAT_GREEN_SLOW) || (selPattern == PAT_GREEN_FAST)) && litNow);

  // lamp is red from reset so power-up shows before the first edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ledRed <= 1'b1;
      ledGreen <= 1'b0;
      powerUpDone <= 1'b0;
    end else if (ce) begin
      ledRed <= next_red;
      ledGreen <= next_green;
      if (puEnd) powerUpDone <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user switch

  // switch is live only after power-up and outside upgrade mode
  wire switchAllowed = (!customerParams || switchReEnabled) &&
    (state != ST_POWERUP) && !upgradeActive;

  sled_switch #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .ATM_HOLD_CYC(ATM_HOLD_CYC),
    .UPGRADE_HOLD_CYC(UPGRADE_HOLD_CYC)
  ) u_switch (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .allow(switchAllowed),
    .switchPressed(switchPressed),
    .vacuumZeroCommand(vacuumZeroCommand),
    .atmosphereAdjustCommand(atmosphereAdjustCommand),
    .upgradeEntryCommand(upgradeEntryCommand)
  );

  ////////////////////////////////////////////////////////////////////////////
  // factory adjustment store; switch actions never write it, so an
  // accidental press can always be undone

  logic [ADJ_W-1:0] factoryZero;
  logic [ADJ_W-1:0] factoryAtm;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      factoryZero <= FACTORY_RESET_VAL;
      factoryAtm <= FACTORY_RESET_VAL;
    end else if (ce && factoryStore) begin
      factoryZero <= factoryZeroIn;
      factoryAtm <= factoryAtmIn;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      restoredZero <= FACTORY_RESET_VAL;
      restoredAtm <= FACTORY_RESET_VAL;
      restoredZeroValid <= 1'b0;
      restoredAtmValid <= 1'b0;
    end else if (ce) begin
      restoredZeroValid <= restoreFactoryZeroCommand;
      restoredAtmValid <= restoreFactoryAtmosphereCommand;
      if (restoreFactoryZeroCommand) restoredZero <= factoryZero;
      if (restoreFactoryAtmosphereCommand) restoredAtm <= factoryAtm;
    end
  end
endmodule : sled_top
`default_nettype wire

// >>> core/sled_pkg.sv
// constants shared by the status lamp and user switch logic
package sled_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  // times in milliseconds, cycle counts derived from CLK_HZ
  localparam int unsigned POWERUP_MS = 2000;
  localparam int unsigned SLOW_FLASH_MS = 1000;
  localparam int unsigned FAST_FLASH_MS = 500;
  localparam int unsigned BURST_FLASH_MS = 500;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned ATM_HOLD_MS = 3000;
  localparam int unsigned UPGRADE_HOLD_MS = 8000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam logic [31:0] POWERUP_CYC = 32'(POWERUP_MS * CYC_PER_MS);
  // a flash cycle is one lit half and one dark half
  localparam logic [31:0] SLOW_HALF_CYC = 32'(SLOW_FLASH_MS * CYC_PER_MS / 2);
  localparam logic [31:0] FAST_HALF_CYC = 32'(FAST_FLASH_MS * CYC_PER_MS / 2);
  localparam logic [31:0] BURST_HALF_CYC = 32'(BURST_FLASH_MS * CYC_PER_MS / 2);
  localparam logic [31:0] DEBOUNCE_CYC = 32'(DEBOUNCE_MS * CYC_PER_MS);
  localparam logic [31:0] ATM_HOLD_CYC = 32'(ATM_HOLD_MS * CYC_PER_MS);
  localparam logic [31:0] UPGRADE_HOLD_CYC = 32'(UPGRADE_HOLD_MS * CYC_PER_MS);
  localparam logic [2:0] BURST_FLASHES = 3'h3;
  localparam int unsigned ADJ_W = 16;
  localparam logic [ADJ_W-1:0] FACTORY_RESET_VAL = 16'h0000;
  // lamp patterns
  localparam logic [2:0] PAT_OFF = 3'h0;
  localparam logic [2:0] PAT_GREEN = 3'h1;
  localparam logic [2:0] PAT_RED = 3'h2;
  localparam logic [2:0] PAT_GREEN_SLOW = 3'h3;
  localparam logic [2:0] PAT_GREEN_FAST = 3'h4;
  localparam logic [2:0] PAT_RED_FAST = 3'h5;
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b001,
    ST_RUN = 3'b010,
    ST_BURST = 3'b100
  } sled_state_t;
endpackage : sled_pkg

// >>> core/sled_switch.sv
// debounce and hold-time classification of the user push switch
`timescale 1ns/1ps
`default_nettype none
module sled_switch #(
  parameter logic [31:0] DEBOUNCE_CYC = sled_pkg::DEBOUNCE_CYC,
  parameter logic [31:0] ATM_HOLD_CYC = sled_pkg::ATM_HOLD_CYC,
  parameter logic [31:0] UPGRADE_HOLD_CYC = sled_pkg::UPGRADE_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic allow,
  input wire logic switchPressed,
  output logic vacuumZeroCommand,
  output logic atmosphereAdjustCommand,
  output logic upgradeEntryCommand
);
  import sled_pkg::*;

  logic stable;
  logic [31:0] debCnt;
  logic [31:0] holdCnt;
  logic armed;
  wire differs = switchPressed != stable;
  wire debDone = differs && (debCnt >= DEBOUNCE_CYC - 32'h1);
  wire released = debDone && stable;
  wire holdAtm = holdCnt >= ATM_HOLD_CYC;
  wire holdUpg = holdCnt >= UPGRADE_HOLD_CYC;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stable <= 1'b0;
      debCnt <= 32'h0;
    end else if (ce) begin
      debCnt <= (differs && !debDone) ? debCnt + 32'h1 : 32'h0;
      if (debDone) stable <= switchPressed;
    end
  end

  // a press is only armed if the switch was allowed when it went down,
  // so re-enabling mid-press cannot fire a half-measured action
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      holdCnt <= 32'h0;
      armed <= 1'b0;
    end else if (ce) begin
      if (debDone && !stable) begin
        armed <= allow;
        holdCnt <= 32'h0;
      end else if (stable && !holdUpg) begin
        holdCnt <= holdCnt + 32'h1;
      end
      if (!allow) armed <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vacuumZeroCommand <= 1'b0;
      atmosphereAdjustCommand <= 1'b0;
      upgradeEntryCommand <= 1'b0;
    end else if (ce) begin
      vacuumZeroCommand <= released && armed && allow && !holdAtm;
      atmosphereAdjustCommand <= released && armed && allow && holdAtm && !holdUpg;
      upgradeEntryCommand <= released && armed && allow && holdUpg;
    end
  end
endmodule : sled_switch
`default_nettype wire

// >>> tb/sled_operator.sv
// operator model: holds the push switch for a set time after one contact bounce
`timescale 1ns/1ps
`default_nettype none
module sled_operator (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [7:0] holdLen,
  output logic switchPressed
);
  logic [7:0] left = 8'h0;
  logic gap = 1'h0;
  initial switchPressed = 1'h0;
  // the open gap after the first touch is a bounce the debouncer must swallow
  always @(posedge ref_clk) begin
    gap <= go;
    left <= go ? holdLen : (left != 8'h0 ? left - 8'h1 : left);
    switchPressed <= go || (!gap && left > 8'h1);
  end
endmodule : sled_operator
`default_nettype wire

// >>> tb/sled_top_chk.sv
// concurrent checks on the lamp sequencer and switch front end
`timescale 1ns/1ps
`default_nettype none
module sled_top_chk #(
  parameter logic [31:0] BURST_HALF_CYC = 32'h4,
  parameter logic [31:0] DEBOUNCE_CYC = 32'h3
) (
  input wire logic ref_clk, nrst, ce, testModeActive, hvOn, sensorFail, upgradeActive,
  input wire logic adjustDone, adjustOk, customerParams, switchReEnabled, factoryStore,
  input wire logic restoreFactoryZeroCommand, ledRed, ledGreen, powerUpDone, restoredZeroValid,
  input wire logic vacuumZeroCommand, atmosphereAdjustCommand, upgradeEntryCommand,
  input wire logic [sled_pkg::ADJ_W-1:0] factoryZeroIn, restoredZero
);
  import sled_pkg::*;
  logic [31:0] sinceAdj, allowAge;
  logic adjOk;
  logic [ADJ_W-1:0] zeroKept;
  wire allowNow = (!customerParams || switchReEnabled) && powerUpDone && !upgradeActive;
  wire cmdAny = vacuumZeroCommand || atmosphereAdjustCommand || upgradeEntryCommand;
  wire inBurst = sinceAdj != 32'h0 && sinceAdj <= 32'h6 * BURST_HALF_CYC;
  wire [31:0] halfIdx = (sinceAdj - 32'h1) / BURST_HALF_CYC;
  wire lit = !halfIdx[0];
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sinceAdj <= '1;
      allowAge <= '0;
      adjOk <= 1'h0;
      zeroKept <= FACTORY_RESET_VAL;
    end else if (ce) begin
      if (adjustDone && powerUpDone) sinceAdj <= '0;
      else if (sinceAdj != '1) sinceAdj <= sinceAdj + 32'h1;
      if (adjustDone && powerUpDone) adjOk <= adjustOk;
      allowAge <= !allowNow ? '0 : (allowAge == '1 ? allowAge : allowAge + 32'h1);
      if (factoryStore) zeroKept <= factoryZeroIn;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_adjGood; adjustDone && adjustOk && powerUpDone && ce; endsequence
  sequence s_quiet; ce && !sensorFail && !upgradeActive && !adjustDone; endsequence
  property p_powerUpRed; !powerUpDone |-> ledRed && !ledGreen; endproperty
  a_powerUpRed: assert property (p_powerUpRed) else $error("not red");
  property p_dark; $past(ce && powerUpDone && upgradeActive) |-> !ledRed && !ledGreen; endproperty
  a_dark: assert property (p_dark) else $error("not dark");
  property p_failRed;
    $past(ce && powerUpDone && sensorFail && !upgradeActive) |-> ledRed && !ledGreen;
  endproperty
  a_failRed: assert property (p_failRed) else $error("fail not red");
  property p_normal;
    sinceAdj > 32'h6 * BURST_HALF_CYC && $past(ce && powerUpDone && !upgradeActive
      && !sensorFail && !testModeActive && !hvOn) |-> ledGreen && !ledRed;
  endproperty
  a_normal: assert property (p_normal) else $error("not green");
  property p_burst;
    inBurst && $past(ce && !sensorFail && !upgradeActive)
      |-> ledGreen == (adjOk && lit) && ledRed == (!adjOk && lit);
  endproperty
  a_burst: assert property (p_burst) else $error("burst wrong");
  property p_burstStart; s_adjGood ##1 s_quiet |=> ledGreen && !ledRed; endproperty
  a_burstStart: assert property (p_burstStart) else $error("burst late");
  property p_cmdPulse;
    cmdAny |-> $onehot({vacuumZeroCommand, atmosphereAdjustCommand, upgradeEntryCommand})
      ##1 !cmdAny;
  endproperty
  a_cmdPulse: assert property (p_cmdPulse) else $error("command not pulse");
  property p_cmdAllowed; cmdAny |-> allowAge > DEBOUNCE_CYC; endproperty
  a_cmdAllowed: assert property (p_cmdAllowed) else $error("switch not ignored");
  property p_restore;
    restoreFactoryZeroCommand && ce && !factoryStore
      |=> restoredZeroValid && restoredZero == zeroKept;
  endproperty
  a_restore: assert property (p_restore) else $error("restore wrong");
endmodule : sled_top_chk
bind sled_top sled_top_chk #(.BURST_HALF_CYC(BURST_HALF_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC))
  chk (.*);
`default_nettype wire

// >>> tb/sled_top_bench.sv
// self-checking bench for the status lamp and switch block
`timescale 1ns/1ps
`default_nettype none
module sled_top_bench;
  import sled_pkg::*;
  localparam logic [31:0] PU = 32'h28, SH = 32'ha, FH = 32'h5, BH = 32'h4;
  logic ref_clk = 1'h0, nrst = 1'h0, ce = 1'h1, go = 1'h0, switchPressed;
  logic testModeActive = 1'h0, hvOn = 1'h0, ionStarted = 1'h0, sensorFail = 1'h0;
  logic upgradeActive = 1'h0, adjustDone = 1'h0, adjustOk = 1'h0, factoryStore = 1'h0;
  logic customerParams = 1'h0, switchReEnabled = 1'h0;
  logic restoreFactoryZeroCommand = 1'h0, restoreFactoryAtmosphereCommand = 1'h0;
  logic [ADJ_W-1:0] factoryZeroIn = '0, factoryAtmIn = '0, restoredZero, restoredAtm, z, a;
  logic ledRed, ledGreen, powerUpDone, vacuumZeroCommand, atmosphereAdjustCommand;
  logic upgradeEntryCommand, restoredZeroValid, restoredAtmValid;
  logic [7:0] holdLen = 8'h0;
  logic [2:0] got, c;
  logic [1:0] was, cur;
  int errors = 0, compares = 0, n;
  sled_top #(.POWERUP_CYC(PU), .SLOW_HALF_CYC(SH), .FAST_HALF_CYC(FH), .BURST_HALF_CYC(BH),
    .DEBOUNCE_CYC(32'h3), .ATM_HOLD_CYC(32'h14), .UPGRADE_HOLD_CYC(32'h28)) dut (.*);
  sled_operator op (.ref_clk(ref_clk), .go(go), .holdLen(holdLen), .switchPressed(switchPressed));
  always #2.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // sample 1 ns after the edge so registered outputs have settled
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick
  function automatic logic [31:0] expHalf(input logic [2:0] m);
    return m[2] ? SH : (m[1] ? FH : 32'h0);
  endfunction : expHalf
  function automatic logic [1:0] expLit(input logic [2:0] m);
    return (!m[2] && m[1] && !m[0]) ? 2'h2 : 2'h1;
  endfunction : expLit
  ////////////////////////////////////////
  initial begin
    void'($urandom(56));
    repeat (4) @(posedge ref_clk);
    nrst <= 1'h1;
    tick(10);
    check("red", {ledRed, ledGreen}, 2'h2);
    // a result pulse during power-up must leave no burst behind
    @(posedge ref_clk);
    adjustDone <= 1'h1;
    @(posedge ref_clk);
    adjustDone <= 1'h0;
    n = 12;
    while (powerUpDone !== 1'h1 && n < 200) begin tick(1); n++; end
    check("powerup", n >= PU - 1 && n <= PU + 1, 32'h1);
    tick(3);
    check("green", {ledRed, ledGreen}, 2'h1);
    for (int i = 0; i < 12; i++) begin
      c = i < 8 ? i[2:0] : 3'($urandom);
      @(posedge ref_clk);
      sensorFail <= 1'h1;
      {testModeActive, hvOn, ionStarted} <= c;
      tick(3);
      check("fail", {ledRed, ledGreen}, 2'h2);
      @(posedge ref_clk);
      sensorFail <= 1'h0;
      tick(2);
      check("lit", {ledRed, ledGreen}, expLit(c));
      n = 0;
      while ({ledRed, ledGreen} === expLit(c) && n < 40) begin tick(1); n++; end
      // one lit cycle was already seen before counting; steady runs to the limit
      check("litHalf", n, expHalf(c) == 32'h0 ? 32'h28 : expHalf(c) - 32'h1);
      n = 0;
      while ({ledRed, ledGreen} === 2'h0 && n < 40) begin tick(1); n++; end
      check("half", n, expHalf(c));
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      {testModeActive, hvOn, ionStarted} <= 3'h0;
      tick(3);
      @(posedge ref_clk);
      adjustDone <= 1'h1;
      adjustOk <= k[0];
      @(posedge ref_clk);
      adjustDone <= 1'h0;
      tick(0);
      was = {ledRed, ledGreen};
      n = 0;
      repeat (34) begin
        tick(1);
        cur = {ledRed, ledGreen};
        if (was[k[0] ? 0 : 1] === 1'h1 && cur[k[0] ? 0 : 1] === 1'h0) n++;
        was = cur;
      end
      check("flashes", n, 32'h3);
      check("after", {ledRed, ledGreen}, 2'h1);
    end
    // a low enable must freeze the red blink in its lit half
    @(posedge ref_clk);
    hvOn <= 1'h1;
    tick(3);
    @(posedge ref_clk);
    ce <= 1'h0;
    tick(0);
    was = {ledRed, ledGreen};
    tick(12);
    check("freeze", {ledRed, ledGreen}, was);
    @(posedge ref_clk);
    ce <= 1'h1;
    hvOn <= 1'h0;
    @(posedge ref_clk);
    upgradeActive <= 1'h1;
    sensorFail <= 1'h1;
    tick(3);
    check("dark", {ledRed, ledGreen}, 2'h0);
    z = 16'($urandom);
    a = 16'($urandom);
    @(posedge ref_clk);
    upgradeActive <= 1'h0;
    sensorFail <= 1'h0;
    factoryZeroIn <= z;
    factoryAtmIn <= a;
    factoryStore <= 1'h1;
    @(posedge ref_clk);
    factoryStore <= 1'h0;
    factoryZeroIn <= ~z;
    factoryAtmIn <= ~a;
    // short, medium and long holds; the middle three with customer parameters
    for (int k = 0; k < 9; k++) begin
      @(posedge ref_clk);
      customerParams <= k / 3 == 1;
      switchReEnabled <= k == 4;
      holdLen <= (k % 3 == 0 ? 8'h6 : (k % 3 == 1 ? 8'h1a : 8'h32)) + 8'($urandom % 8);
      go <= 1'h1;
      @(posedge ref_clk);
      go <= 1'h0;
      got = 3'h0;
      repeat (90) begin
        tick(1);
        got = got | {upgradeEntryCommand, atmosphereAdjustCommand, vacuumZeroCommand};
      end
      check("command", got, (k == 3 || k == 5) ? 3'h0 : 3'h1 << (k % 3));
    end
    @(posedge ref_clk);
    restoreFactoryZeroCommand <= 1'h1;
    restoreFactoryAtmosphereCommand <= 1'h1;
    @(posedge ref_clk);
    restoreFactoryZeroCommand <= 1'h0;
    restoreFactoryAtmosphereCommand <= 1'h0;
    tick(0);
    check("zero", {restoredZeroValid, restoredZero}, {1'h1, z});
    check("atm", {restoredAtmValid, restoredAtm}, {1'h1, a});
    summarize();
  end
  initial begin
    repeat (10000) @(posedge ref_clk);
    errors++;
    summarize();
  end
endmodule : sled_top_bench
`default_nettype wire
